// [include/noise_random_source_pkg.sv]
/*
  Constants and types shared by the noise-based random word generator: register offsets,
  field layouts, reset values, timing bounds and the generation state encoding.
  Assumes a 32-bit AHB-Lite register port with one aligned word per register.
*/
`default_nettype none

package noise_random_source_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, low eight address bits).
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_WORD_LOW = 8'h00;
  localparam logic [7:0] OFS_WORD_HIGH = 8'h04;
  localparam logic [7:0] OFS_STATE_WORD = 8'h08;
  localparam logic [7:0] OFS_ACK_WORD = 8'h0C;
  localparam logic [7:0] OFS_CONTROL_WORD = 8'h10;
  localparam logic [7:0] OFS_SETUP_WORD = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h1C;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h20;

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int ENABLE_BIT = 0;
  localparam int WARMUP_LSB = 16;
  localparam int FIELD_W = 16;
  localparam int FLOOR_LSB = 0;
  localparam int CEIL_LSB = 16;
  localparam int READY_BIT = 0;
  localparam int BUSY_BIT = 1;
  localparam int STATE_LSB = 4;
  localparam int IRQ_W = 2;
  localparam int IRQ_READY_BIT = 0;
  localparam int IRQ_STRAY_ACK_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] SETUP_RESET = 32'h0000_0000;
  localparam logic [63:0] WORD_RESET = 64'h0000_0000_0000_0000;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Timing: sample counts in clock cycles.
  // ----------------------------------------------------------------
  localparam int CNT_W = 25;
  localparam int WARMUP_UNIT_SHIFT = 8;
  localparam int FLOOR_UNIT_SHIFT = 6;
  localparam int CEIL_UNIT_SHIFT = 8;
  localparam int FIRST_MIN_CYCLES = 2 ** 8;
  localparam int FIRST_MAX_CYCLES = 2 ** 24;
  localparam int NEXT_MIN_CYCLES = 2 ** 6;
  localparam int NEXT_MAX_CYCLES = 2 ** 24;

  // ----------------------------------------------------------------
  // Generation states.
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WARMUP = 2'b01,
    ST_HOLD = 2'b10,
    ST_REFILL = 2'b11
  } gen_state_type;

endpackage

`default_nettype wire

// [include/noise_link_if.sv]
/*
  Link between the generation controller and the oscillator and shift register block.
  Assumes both ends run on the same clock.
*/
`default_nettype none

interface noise_link_if;
  logic sample_en;
  logic [63:0] shift_value;

  modport ctrl (output sample_en, input shift_value);
  modport source (input sample_en, output shift_value);
endinterface

`default_nettype wire

// [logic/noise_sample_shifter.sv]
/*
  Oscillator stand-ins, stepped only while sampling, and the 64-bit shift register that gathers their samples.
  Assumes hclk, an asynchronous active-low reset and a clock enable shared with the controller.
*/
`default_nettype none

module noise_sample_shifter #(
  parameter int OSC_COUNT = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  noise_link_if.source link
);

  // ----------------------------------------------------------------
  // Oscillators: each a small feedback register, run only while sampling.
  // ----------------------------------------------------------------
  logic [OSC_COUNT-1:0] osc_bit;
  logic sample_bit;
  logic [63:0] shift_q;
  logic [63:0] shift_d;

  for (genvar i = 0; i < OSC_COUNT; i++) begin : g_osc
    logic [6:0] osc_q;
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        osc_q <= 7'(i * 13 + 1);
      end else if (clk_en && link.sample_en) begin
        osc_q <= {osc_q[5:0], osc_q[6] ^ osc_q[5 - (i % 3)]};
      end
    end
    assign osc_bit[i] = osc_q[0];
  end

  // ----------------------------------------------------------------
  // Shift register: the value stays frozen whenever sampling stops.
  // ----------------------------------------------------------------
  assign sample_bit = ^osc_bit;
  assign shift_d = {shift_q[62:0], shift_q[63] ^ shift_q[62] ^ shift_q[60] ^ shift_q[59]
                    ^ sample_bit};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_q <= 64'h0000_0000_0000_0000;
    end else if (clk_en && link.sample_en) begin
      shift_q <= shift_d;
    end
  end

  assign link.shift_value = shift_q;

endmodule

`default_nettype wire

// [logic/noise_random_source.sv]
/*
  Noise-based random word generator with an AHB-Lite register port and one level interrupt.
  The block holds the bus slave, the register file, the generation sequencer, the ready
  flag and the interrupt logic; the oscillators and shift register sit in a submodule.
  Assumes a single hclk domain, an asynchronous active-low reset and a zero-wait-state bus.
  Assumes that software reads the low word before the high word of each value, since the
  low read is what copies the shift register into the output words.
  Assumes that clk_en low also stalls the bus, so no transfer is issued while it is low.
*/
// Local design decisions: register access over AHB-Lite and the register offsets.
`default_nettype none

module noise_random_source #(
  parameter int OSC_COUNT = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  // Width of the interrupt fields, kept local so the declarations stay short.
  localparam int IRQ_W_LOCAL = noise_random_source_pkg::IRQ_W;

  noise_link_if link ();

  logic addr_take;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] wdata;
  logic wr_ack;
  logic wr_control;
  logic wr_setup;
  logic wr_irq_clear;
  logic wr_irq_enable;
  logic rd_take;
  logic [7:0] rd_addr;
  logic rd_low;

  logic [31:0] control_q;
  logic [31:0] setup_q;
  logic [63:0] word_q;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  logic ready_q;
  logic [IRQ_W_LOCAL-1:0] irq_status_q;
  logic [IRQ_W_LOCAL-1:0] irq_status_d;
  logic [IRQ_W_LOCAL-1:0] irq_enable_q;
  logic [IRQ_W_LOCAL-1:0] irq_event;

  noise_random_source_pkg::gen_state_type state_q;
  noise_random_source_pkg::gen_state_type state_d;
  logic [noise_random_source_pkg::CNT_W-1:0] count_q;
  logic [noise_random_source_pkg::CNT_W-1:0] count_d;

  logic enable;
  logic [15:0] warmup_field;
  logic [15:0] floor_field;
  logic [15:0] ceil_field;
  logic [noise_random_source_pkg::CNT_W-1:0] warmup_cycles;
  logic [noise_random_source_pkg::CNT_W-1:0] floor_cycles;
  logic [noise_random_source_pkg::CNT_W-1:0] ceil_cycles;
  logic warmup_done;
  logic refill_done;
  logic ack_ready;
  logic value_done;

  // ----------------------------------------------------------------
  // Bus slave: address phase capture and decode.
  // ----------------------------------------------------------------
  assign addr_take = hsel && hready && htrans[1];
  assign rd_take = addr_take && !hwrite;
  assign rd_addr = haddr[7:0];
  assign rd_low = rd_take && (rd_addr == noise_random_source_pkg::OFS_WORD_LOW);

  // Write data arrive one cycle after the address, so the write is remembered for
  // its data phase and decoded there.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (clk_en) begin
      wr_pend_q <= addr_take && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  assign wdata = hwdata;
  assign wr_ack = wr_pend_q && (wr_addr_q == noise_random_source_pkg::OFS_ACK_WORD);
  assign wr_control = wr_pend_q && (wr_addr_q == noise_random_source_pkg::OFS_CONTROL_WORD);
  assign wr_setup = wr_pend_q && (wr_addr_q == noise_random_source_pkg::OFS_SETUP_WORD);
  assign wr_irq_clear = wr_pend_q && (wr_addr_q == noise_random_source_pkg::OFS_IRQ_CLEAR);
  assign wr_irq_enable = wr_pend_q && (wr_addr_q == noise_random_source_pkg::OFS_IRQ_ENABLE);

  // Every transfer completes without wait states and with an OKAY response.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // Bus slave: read data, taken in the address phase, shown in the data phase.
  // ----------------------------------------------------------------
  always_comb begin
    hrdata_d = 32'h0000_0000;
    unique case (rd_addr)
      noise_random_source_pkg::OFS_WORD_LOW: begin
        // The low half comes straight from the shift register; the same edge copies
        // the whole register into word_q, so the high half read next matches it.
        hrdata_d = link.shift_value[31:0];
      end
      noise_random_source_pkg::OFS_WORD_HIGH: begin
        hrdata_d = word_q[63:32];
      end
      noise_random_source_pkg::OFS_STATE_WORD: begin
        hrdata_d[noise_random_source_pkg::READY_BIT] = ready_q;
        hrdata_d[noise_random_source_pkg::BUSY_BIT] = link.sample_en;
        hrdata_d[noise_random_source_pkg::STATE_LSB +: 2] = state_q;
      end
      noise_random_source_pkg::OFS_CONTROL_WORD: begin
        hrdata_d = control_q;
      end
      noise_random_source_pkg::OFS_SETUP_WORD: begin
        hrdata_d = setup_q;
      end
      noise_random_source_pkg::OFS_IRQ_STATUS: begin
        hrdata_d[IRQ_W_LOCAL-1:0] = irq_status_q;
      end
      noise_random_source_pkg::OFS_IRQ_ENABLE: begin
        hrdata_d[IRQ_W_LOCAL-1:0] = irq_enable_q;
      end
      default: begin
        hrdata_d = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (clk_en && rd_take) begin
      hrdata_q <= hrdata_d;
    end
  end

  assign hrdata = hrdata_q;

  // ----------------------------------------------------------------
  // Output words: a read of the low word copies the whole shift register.
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word_q <= noise_random_source_pkg::WORD_RESET;
    end else if (clk_en && rd_low) begin
      word_q <= link.shift_value;
    end
  end

  // ----------------------------------------------------------------
  // Control and setup words.
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control_q <= noise_random_source_pkg::CONTROL_RESET;
      setup_q <= noise_random_source_pkg::SETUP_RESET;
    end else if (clk_en) begin
      if (wr_control) begin
        control_q <= wdata;
      end
      if (wr_setup) begin
        setup_q <= wdata;
      end
    end
  end

  // Field extraction: enable, warm-up count, refill floor and refill ceiling.
  assign enable = control_q[noise_random_source_pkg::ENABLE_BIT];
  assign warmup_field = control_q[noise_random_source_pkg::WARMUP_LSB +: 16];
  assign floor_field = setup_q[noise_random_source_pkg::FLOOR_LSB +: 16];
  assign ceil_field = setup_q[noise_random_source_pkg::CEIL_LSB +: 16];

  // ----------------------------------------------------------------
  // Sample count bounds. A zero field stands for the largest count (warm-up and
  // ceiling) or the smallest (floor), so no setting leaves the bounds.
  // ----------------------------------------------------------------
  assign warmup_cycles = (warmup_field == 16'h0000)
      ? 25'(noise_random_source_pkg::FIRST_MAX_CYCLES)
      : 25'({9'h000, warmup_field} << noise_random_source_pkg::WARMUP_UNIT_SHIFT);
  assign floor_cycles = (floor_field == 16'h0000)
      ? 25'(noise_random_source_pkg::NEXT_MIN_CYCLES)
      : 25'({9'h000, floor_field} << noise_random_source_pkg::FLOOR_UNIT_SHIFT);
  assign ceil_cycles = (ceil_field == 16'h0000)
      ? 25'(noise_random_source_pkg::NEXT_MAX_CYCLES)
      : 25'({9'h000, ceil_field} << noise_random_source_pkg::CEIL_UNIT_SHIFT);

  // Both counts compare count_q + 1, so a bound of N ends after exactly N sampling cycles.
  assign warmup_done = (count_q + 25'h000_0001) >= warmup_cycles;
  // Past the floor the refill ends on a noise bit; the ceiling ends it in any case.
  assign refill_done = (((count_q + 25'h000_0001) >= floor_cycles) && link.shift_value[0])
      || ((count_q + 25'h000_0001) >= ceil_cycles);

  // Only the ready position of an acknowledge write counts; the other bits are ignored.
  assign ack_ready = wr_ack && wdata[noise_random_source_pkg::READY_BIT];

  // ----------------------------------------------------------------
  // Generation sequence.
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    count_d = count_q;
    value_done = 1'b0;
    unique case (state_q)
      noise_random_source_pkg::ST_IDLE: begin
        if (enable) begin
          state_d = noise_random_source_pkg::ST_WARMUP;
          count_d = '0;
        end
      end
      noise_random_source_pkg::ST_WARMUP: begin
        count_d = count_q + 25'h000_0001;
        if (warmup_done) begin
          state_d = noise_random_source_pkg::ST_HOLD;
          value_done = 1'b1;
        end
      end
      noise_random_source_pkg::ST_HOLD: begin
        // Only an acknowledge of a ready value restarts sampling; a stray one is
        // flagged in the interrupt status and otherwise ignored.
        if (ack_ready && ready_q) begin
          state_d = noise_random_source_pkg::ST_REFILL;
          count_d = '0;
        end
      end
      noise_random_source_pkg::ST_REFILL: begin
        count_d = count_q + 25'h000_0001;
        if (refill_done) begin
          state_d = noise_random_source_pkg::ST_HOLD;
          value_done = 1'b1;
        end
      end
    endcase
    // Clearing the enable bit abandons any value in progress and returns to idle.
    if (!enable) begin
      state_d = noise_random_source_pkg::ST_IDLE;
      count_d = '0;
      value_done = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= noise_random_source_pkg::ST_IDLE;
      count_q <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  // Sampling runs only while a value is being built; in HOLD the value stays put.
  assign link.sample_en = (state_q == noise_random_source_pkg::ST_WARMUP)
      || (state_q == noise_random_source_pkg::ST_REFILL);

  // ----------------------------------------------------------------
  // Ready flag: set on completion, cleared by acknowledge or by disabling.
  // ----------------------------------------------------------------
  // A value completes only while ready is low, so a completion and an acknowledge of
  // a ready value never meet; should both fall in one cycle, the completion wins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_q <= 1'b0;
    end else if (clk_en) begin
      if (value_done) begin
        ready_q <= 1'b1;
      end else if (ack_ready || !enable) begin
        ready_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts: sticky events, write-one-to-clear, enable mask.
  // ----------------------------------------------------------------
  assign irq_event[noise_random_source_pkg::IRQ_READY_BIT] = value_done;
  // Bit 1 marks an acknowledge written while no value was ready, a slip in the
  // order that software should keep.
  assign irq_event[noise_random_source_pkg::IRQ_STRAY_ACK_BIT] = ack_ready && !ready_q;

  // A new event wins over a clear written in the same cycle.
  assign irq_status_d = (irq_status_q
      & ~(wr_irq_clear ? wdata[IRQ_W_LOCAL-1:0] : {IRQ_W_LOCAL{1'b0}})) | irq_event;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_q <= noise_random_source_pkg::IRQ_RESET;
      irq_enable_q <= noise_random_source_pkg::IRQ_RESET;
    end else if (clk_en) begin
      irq_status_q <= irq_status_d;
      if (wr_irq_enable) begin
        irq_enable_q <= wdata[IRQ_W_LOCAL-1:0];
      end
    end
  end

  assign irq = |(irq_status_q & irq_enable_q);

  // ----------------------------------------------------------------
  // Oscillators and shift register.
  // ----------------------------------------------------------------
  // The submodule samples only while link.sample_en is high, so a held value stays
  // put until it is acknowledged.
  noise_sample_shifter #(
    .OSC_COUNT(OSC_COUNT)
  ) u_shifter (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .link(link)
  );

endmodule

`default_nettype wire

// [verification/noise_random_source_assertions.sv]
/*
  Port-level assertion checker for the noise random source.
  Assumes hready is tied to hreadyout, one hclk domain and irq enable bit1 left clear.
*/
`default_nettype none

module noise_random_source_assertions #(
  parameter int OSC_COUNT = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;

  logic wr_q;
  logic warm_q;
  logic ien_q;
  logic [7:0] addr_q;
  logic [15:0] cyc_q;
  wire logic take = hsel & hready & htrans[1] & clk_en;
  wire logic rd_take = take & ~hwrite;
  wire logic wr_now = wr_q & clk_en;
  wire logic en_go = wr_now & (addr_q == noise_random_source_pkg::OFS_CONTROL_WORD) & hwdata[0];
  wire logic ack_go = wr_now & (addr_q == noise_random_source_pkg::OFS_ACK_WORD) & hwdata[0];
  wire logic ien_wr = wr_now & (addr_q == noise_random_source_pkg::OFS_IRQ_ENABLE);

  // Tracks the data phase of writes and counts cycles since enable or acknowledge.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      warm_q <= 1'b0;
      ien_q <= 1'b0;
      cyc_q <= 16'h0000;
    end else if (clk_en) begin
      wr_q <= take & hwrite;
      addr_q <= take ? haddr[7:0] : addr_q;
      warm_q <= en_go | (warm_q & ~ack_go);
      ien_q <= ien_wr ? hwdata[0] : ien_q;
      cyc_q <= (en_go | ack_go) ? 16'h0000 : cyc_q + {15'h0000, cyc_q != 16'hFFFF};
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_value_up;
    $rose(irq);
  endsequence
  sequence s_enable_armed;
    en_go && ien_q;
  endsequence

  a_bus_ready: assert property (hreadyout)
    else $error("hreadyout dropped");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_rdata_hold: assert property (!rd_take && !$past(rd_take) |-> $stable(hrdata))
    else $error("read data changed without a read");
  a_reset_quiet: assert property ($rose(hresetn) |-> !irq && hrdata == 32'h0000_0000)
    else $error("outputs not quiet after reset");
  a_warmup_floor: assert property (s_value_up ##0 warm_q |-> cyc_q >= 16'h00FA)
    else $error("first value came too early");
  a_refill_floor: assert property (s_value_up ##0 !warm_q |-> cyc_q >= 16'h003C)
    else $error("refilled value came too early");
  a_first_bound: assert property (s_enable_armed |-> ##[250:300] irq)
    else $error("first value came too late");
  a_irq_sticky: assert property (irq && !wr_now |=> irq)
    else $error("ready interrupt dropped without a write");
endmodule

`default_nettype wire

// [verification/noise_random_source_test.sv]
/*
  Self-checking testbench for the noise random source over AHB-Lite.
  Assumes the package is compiled first and the checker file is compiled alongside.
*/
`default_nettype none

module noise_random_source_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic clk_en = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic irq;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  int mark;
  logic [31:0] rd;
  logic [31:0] lo;
  logic [31:0] hi;
  logic [7:0] zero_ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24};

  noise_random_source #(.OSC_COUNT(4)) u_noise_random_source (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq)
  );

  always #25 hclk = ~hclk;

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end

  task close_out;
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      bad_count++;
    end
  endtask

  // One single-word transfer: address phase, then data phase, each held until hready.
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] v);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask

  task rchk(input string name, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, a, 32'h0000_0000, v);
    check(name, v, e);
  endtask

  task wait_ready(output int k);
    logic [31:0] v;
    for (int i = 0; i < 400; i++) begin
      bus(1'b0, noise_random_source_pkg::OFS_STATE_WORD, 32'h0000_0000, v);
      if (v[0] === 1'b1) break;
    end
    k = cyc;
  endtask

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (zero_ofs[i]) rchk("reset read", zero_ofs[i], 32'h0000_0000);
    repeat (300) @(posedge hclk);
    rchk("state before enable", noise_random_source_pkg::OFS_STATE_WORD, 32'h0000_0000);
    $display("Test reset and idle done");

    bus(1'b1, noise_random_source_pkg::OFS_SETUP_WORD, 32'h0001_0001, rd);
    bus(1'b1, noise_random_source_pkg::OFS_CONTROL_WORD, 32'h0001_0000, rd);
    bus(1'b1, noise_random_source_pkg::OFS_IRQ_ENABLE, 32'h0000_0001, rd);
    rchk("setup", noise_random_source_pkg::OFS_SETUP_WORD, 32'h0001_0001);
    rchk("control", noise_random_source_pkg::OFS_CONTROL_WORD, 32'h0001_0000);
    bus(1'b1, noise_random_source_pkg::OFS_CONTROL_WORD, 32'h0001_0001, rd);
    mark = cyc;
    wait_ready(n);
    n -= mark;
    check("warm-up wait", {31'h0000_0000, n >= 250 && n <= 270}, 32'h0000_0001);
    check("irq on ready", {31'h0000_0000, irq}, 32'h0000_0001);
    $display("Test warm-up done");

    bus(1'b0, noise_random_source_pkg::OFS_WORD_LOW, 32'h0000_0000, lo);
    bus(1'b0, noise_random_source_pkg::OFS_WORD_HIGH, 32'h0000_0000, hi);
    bus(1'b1, noise_random_source_pkg::OFS_WORD_LOW, ~lo, rd);
    rchk("low again", noise_random_source_pkg::OFS_WORD_LOW, lo);
    rchk("high again", noise_random_source_pkg::OFS_WORD_HIGH, hi);
    rchk("state holding", noise_random_source_pkg::OFS_STATE_WORD, 32'h0000_0021);
    $display("Test read and hold done");

    bus(1'b1, noise_random_source_pkg::OFS_ACK_WORD, 32'h0000_0001, rd);
    mark = cyc;
    rchk("state after ack", noise_random_source_pkg::OFS_STATE_WORD, 32'h0000_0032);
    bus(1'b1, noise_random_source_pkg::OFS_IRQ_CLEAR, 32'h0000_0001, rd);
    rchk("irq cleared", noise_random_source_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
    wait_ready(n);
    n -= mark;
    check("refill wait", {31'h0000_0000, n >= 60 && n <= 270}, 32'h0000_0001);
    bus(1'b0, noise_random_source_pkg::OFS_WORD_LOW, 32'h0000_0000, rd);
    check("new value", {31'h0000_0000, {rd, hi} !== {lo, hi}}, 32'h0000_0001);
    $display("Test refill done");

    bus(1'b1, noise_random_source_pkg::OFS_ACK_WORD, 32'h0000_0001, rd);
    bus(1'b1, noise_random_source_pkg::OFS_ACK_WORD, 32'h0000_0001, rd);
    rchk("stray ack", noise_random_source_pkg::OFS_IRQ_STATUS, 32'h0000_0003);
    clk_en <= 1'b0;
    repeat (300) @(posedge hclk);
    clk_en <= 1'b1;
    rchk("frozen refill", noise_random_source_pkg::OFS_STATE_WORD, 32'h0000_0032);
    bus(1'b1, noise_random_source_pkg::OFS_CONTROL_WORD, 32'h0001_0000, rd);
    repeat (300) @(posedge hclk);
    rchk("disabled", noise_random_source_pkg::OFS_STATE_WORD, 32'h0000_0000);
    $display("Test acknowledge and disable done");
    close_out();
  end
endmodule

bind noise_random_source noise_random_source_assertions #(.OSC_COUNT(OSC_COUNT))
  u_noise_random_source_assertions (
  .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq)
);

`default_nettype wire
